// ===== ext_alu_params.svh
// offsets, field positions, reset values and masks of the shift/subtract slice
// assumes inclusion by bare name from the design files
`ifndef EXT_ALU_PARAMS_SVH
`define EXT_ALU_PARAMS_SVH

`define ALU_ADDR_W 4
`define OFS_STATUS 4'h0
`define OFS_RESULT 4'h4

`define BIT_C 0
`define BIT_Z 1
`define BIT_N 2
`define BIT_V 3
`define BIT_IRQ_EN 4
`define BIT_CORE 5
`define BIT_OSC 6
`define STATUS_W 7
`define STATUS_RST 7'h00
`define RESULT_RST 20'h00000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define MASK_BYTE 20'h000FF
`define MASK_WORD 20'h0FFFF
`define MASK_AWORD 20'hFFFFF

`endif

// ===== ext_alu_pkg.sv
// types shared by the shift/subtract slice
// assumes nothing of its surroundings
package ext_alu_pkg;

    typedef enum logic [2:0]
    {
        shift_right_arith_single = 3'h0,
        shift_right_arith_multi = 3'h1,
        rotate_carry_single = 3'h2,
        rotate_carry_multi = 3'h3,
        shift_unsigned_single = 3'h4,
        shift_unsigned_multi = 3'h5,
        subtract_borrow_ext = 3'h6,
        subtract_ext = 3'h7
    } op_t;

    typedef enum logic [1:0]
    {
        size_byte = 2'h0,
        size_word = 2'h1,
        size_aword = 2'h2
    } op_size_t;

endpackage

// ===== ext_shift_subtract_alu.sv
// shift-right family and extended subtract datapath with status flags
// assumes decode supplies one operation per valid cycle on aclk
//
// Behaviour
// RULE1 - arithmetic shift keeps sign, LSB to carry
// RULE2 - register arithmetic shift zeros bits above size
// RULE3 - single shifts accept memory, never immediate destination
// RULE4 - single shift sets N, Z, C; clears V
// RULE5 - multi rotate moves carry in 1..4 steps
// RULE6 - multi carry is original bit n-1
// RULE7 - multi forms: no extension word, register only
// RULE8 - word multi rotate zeros 19:16, aword keeps
// RULE9 - multi shift sets N, Z; clears V
// RULE10 - single rotate zeros upper bits, carry through MSB
// RULE11 - multi unsigned shift inserts zeros, word zeros 19:16
// RULE12 - single unsigned shift only to register
// RULE13 - borrow subtract adds all-ones plus carry
// RULE14 - borrow subtract sets C, V, N, Z
// RULE15 - carry clear means borrow occurred
// RULE16 - subtract adds inverted source plus one
// RULE17 - subtract Z on equality, N top, C carry
// RULE18 - subtract overflow on sign-mismatch result
// RULE19 - operations never touch mode bits
// RULE20 - result and flags update in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "ext_alu_params.svh"

module ext_shift_subtract_alu
    import ext_alu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ALU_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ALU_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic op_valid,
    input wire op_t op_kind,
    input wire op_size_t op_size,
    input wire logic [2:0] op_count,
    input wire logic op_dst_reg,
    input wire logic op_dst_imm,
    input wire logic op_ext_word,
    input wire logic [19:0] op_src,
    input wire logic [19:0] op_dst,
    output logic res_valid_r,
    output logic res_fault_r,
    output logic [19:0] res_data_r,
    output logic flag_n_r,
    output logic flag_z_r,
    output logic flag_c_r,
    output logic flag_v_r,
    output logic global_irq_enable,
    output logic core_halt_bit,
    output logic oscillator_halt_bit
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [19:0] size_mask(input op_size_t s);
        case (s)
            size_byte: size_mask = `MASK_BYTE;
            size_word: size_mask = `MASK_WORD;
            default: size_mask = `MASK_AWORD;
        endcase
    endfunction

    function automatic logic carry_of(input logic [20:0] s, input op_size_t z);
        case (z)
            size_byte: carry_of = s[8];
            size_word: carry_of = s[16];
            default: carry_of = s[20];
        endcase
    endfunction

    // ****************************************
    // datapath
    // ****************************************
    logic [19:0] mask;
    logic [19:0] top;
    logic [19:0] val;
    logic [19:0] opb;
    logic [20:0] sum;
    logic cy;
    logic cout;
    logic fill;
    logic ovf;
    logic cin;
    logic is_multi;
    logic is_sub;
    logic fault;
    logic [2:0] steps;

    always_comb
    begin
        mask = size_mask(op_size);
        top = mask ^ (mask >> 1);
        val = op_dst & mask;
        cy = flag_c_r;
        cout = 1'b0;
        fill = 1'b0;
        opb = 20'h00000;
        sum = 21'h000000;
        ovf = 1'b0;
        cin = 1'b0;
        is_multi = (op_kind == shift_right_arith_multi) || (op_kind == rotate_carry_multi)
            || (op_kind == shift_unsigned_multi);
        is_sub = (op_kind == subtract_ext) || (op_kind == subtract_borrow_ext);
        steps = is_multi ? op_count : 3'h1;
        for (int i = 0; i < 4; i++)
        begin
            if (!is_sub && (3'(i) < steps))
            begin
                cout = val[0]; // see RULE6
                case (op_kind)
                    shift_right_arith_single, shift_right_arith_multi: fill = |(val & top); // see RULE1
                    rotate_carry_single, rotate_carry_multi: fill = cy; // see RULE5 see RULE10
                    default: fill = 1'b0; // see RULE11 see RULE12
                endcase
                // masking zeros the bits above the size, see RULE2 see RULE8
                val = ((val >> 1) | (fill ? top : 20'h00000)) & mask;
                cy = cout;
            end
        end
        if (is_sub)
        begin
            opb = (op_kind == subtract_ext) ? (~op_src & mask) : mask; // see RULE13 see RULE16
            cin = (op_kind == subtract_ext) ? 1'b1 : flag_c_r; // see RULE15
            sum = {1'b0, op_dst & mask} + {1'b0, opb} + {20'h00000, cin};
            val = sum[19:0] & mask;
            cy = carry_of(sum, op_size); // see RULE14
            ovf = ((|(op_dst & top)) == (|(opb & top))) && ((|(val & top)) != (|(op_dst & top))); // see RULE18
        end
        case (op_kind)
            shift_right_arith_multi, rotate_carry_multi, shift_unsigned_multi:
                fault = op_ext_word || !op_dst_reg || (op_count == 3'h0) || (op_count > 3'h4)
                    || (op_size == size_byte) || (op_size == 2'h3); // see RULE7
            shift_unsigned_single: fault = !op_dst_reg || (op_size == 2'h3); // see RULE12
            shift_right_arith_single, rotate_carry_single:
                fault = (!op_dst_reg && op_dst_imm) || (op_size == 2'h3); // see RULE3
            default: fault = (op_size == 2'h3);
        endcase
    end

    // ****************************************
    // bus write side
    // ****************************************
    logic aw_held_r;
    logic w_held_r;
    logic [`ALU_ADDR_W-1:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic wr_status;

    assign wr_fire = aw_held_r && w_held_r && !bvalid;
    assign wr_status = wr_fire && (waddr_r[`ALU_ADDR_W-1:2] == `OFS_STATUS >> 2) && wstrb_r[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            aw_held_r <= 1'b0;
            waddr_r <= '0;
        end
        else if (awvalid && awready)
        begin
            awready <= 1'b0;
            aw_held_r <= 1'b1;
            waddr_r <= awaddr;
        end
        else
        begin
            if (wr_fire)
                aw_held_r <= 1'b0;
            if (!aw_held_r && !bvalid)
                awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready <= 1'b0;
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            wready <= 1'b0;
            w_held_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end
        else
        begin
            if (wr_fire)
                w_held_r <= 1'b0;
            if (!w_held_r && !bvalid)
                wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            case (waddr_r[`ALU_ADDR_W-1:2])
                `OFS_STATUS >> 2, `OFS_RESULT >> 2: bresp <= `RESP_OKAY;
                default: bresp <= `RESP_SLVERR;
            endcase
        end
        else if (bvalid && bready)
            bvalid <= 1'b0;
    end

    // ****************************************
    // bus read side
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            case (araddr[`ALU_ADDR_W-1:2])
                `OFS_STATUS >> 2:
                begin
                    rdata <= {25'h0000000, oscillator_halt_bit, core_halt_bit, global_irq_enable,
                        flag_v_r, flag_n_r, flag_z_r, flag_c_r};
                    rresp <= `RESP_OKAY;
                end
                `OFS_RESULT >> 2:
                begin
                    rdata <= {12'h000, res_data_r};
                    rresp <= `RESP_OKAY;
                end
                default:
                begin
                    rdata <= 32'h00000000;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
        else if (!rvalid)
            arready <= 1'b1;
    end

    // ****************************************
    // result and flags
    // ****************************************
    op_size_t size_r;
    op_t kind_r;
    localparam logic [`STATUS_W-1:0] status_rst = `STATUS_RST;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            res_valid_r <= 1'b0;
            res_fault_r <= 1'b0;
            res_data_r <= `RESULT_RST;
            size_r <= size_word;
            kind_r <= subtract_ext;
        end
        else
        begin
            res_valid_r <= op_valid && !fault; // see RULE20
            res_fault_r <= op_valid && fault;
            if (op_valid && !fault)
            begin
                res_data_r <= val;
                size_r <= op_size;
                kind_r <= op_kind;
            end
        end
    end

    // operation wins over a software write in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flag_n_r <= status_rst[`BIT_N];
            flag_z_r <= status_rst[`BIT_Z];
            flag_c_r <= status_rst[`BIT_C];
            flag_v_r <= status_rst[`BIT_V];
        end
        else if (op_valid && !fault)
        begin
            flag_n_r <= |(val & top); // see RULE4 see RULE9 see RULE17
            flag_z_r <= (val == 20'h00000);
            flag_c_r <= cy;
            flag_v_r <= ovf;
        end
        else if (wr_status)
        begin
            flag_n_r <= wdata_r[`BIT_N];
            flag_z_r <= wdata_r[`BIT_Z];
            flag_c_r <= wdata_r[`BIT_C];
            flag_v_r <= wdata_r[`BIT_V];
        end
    end

    // mode bits follow software only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            global_irq_enable <= status_rst[`BIT_IRQ_EN];
            core_halt_bit <= status_rst[`BIT_CORE];
            oscillator_halt_bit <= status_rst[`BIT_OSC];
        end
        else if (wr_status)
        begin
            global_irq_enable <= wdata_r[`BIT_IRQ_EN]; // see RULE19
            core_halt_bit <= wdata_r[`BIT_CORE];
            oscillator_halt_bit <= wdata_r[`BIT_OSC];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_arith_sign: assert property (op_valid && !fault && op_kind == shift_right_arith_single
        && op_size == size_word && op_dst_reg |=> res_data_r[15] == $past(op_dst[15])
        && res_data_r[19:16] == 4'h0 && flag_c_r == $past(op_dst[0])) // see RULE1
        else $error("arith shift sign or upper bits wrong");
    a_byte_clear: assert property (res_valid_r && size_r == size_byte |-> res_data_r[19:8] == 12'h000) // see RULE2
        else $error("byte result upper bits not zero");
    a_multi_carry: assert property (op_valid && !fault && is_multi && op_count == 3'h3
        |=> flag_c_r == $past(op_dst[2]) && !flag_v_r) // see RULE6
        else $error("multi shift carry wrong");
    a_multi_reject: assert property (op_valid && is_multi && op_ext_word
        |=> res_fault_r && !res_valid_r && $stable(res_data_r)) // see RULE7
        else $error("multi form with extension word accepted");
    a_rot_top: assert property (op_valid && !fault && op_kind == rotate_carry_single
        && op_size == size_aword |=> res_data_r[19] == $past(flag_c_r)) // see RULE10
        else $error("rotate did not move carry into top");
    a_unsigned_zero: assert property (op_valid && !fault && op_kind == shift_unsigned_multi
        && op_count == 3'h4 && op_size == size_word |=> res_data_r[19:12] == 8'h00) // see RULE11
        else $error("unsigned shift did not insert zeros");
    a_sbc_value: assert property (op_valid && !fault && op_kind == subtract_borrow_ext
        && op_size == size_word |=> res_data_r == ((20'($past(op_dst[15:0])) + 20'h0FFFF
        + 20'($past(flag_c_r))) & `MASK_WORD)) // see RULE13
        else $error("borrow subtract result wrong");
    a_sub_zero: assert property (res_valid_r && kind_r == subtract_ext
        |-> flag_z_r == (($past(op_src) & size_mask(size_r)) == ($past(op_dst) & size_mask(size_r)))) // see RULE17
        else $error("subtract zero flag wrong");
    a_mode_hold: assert property (!$past(wr_status) |-> $stable({global_irq_enable,
        core_halt_bit, oscillator_halt_bit})) // see RULE19
        else $error("mode bits changed without write");
    a_flag_cause: assert property ($changed(flag_c_r) |-> res_valid_r || $past(wr_status)) // see RULE20
        else $error("carry changed without completion");

    c_multi_rot: cover property (op_valid && !fault && op_kind == rotate_carry_multi
        ##1 res_valid_r);
    c_sub_ovf: cover property (res_valid_r && kind_r == subtract_ext && flag_v_r);
    c_fault: cover property (res_fault_r);
    c_axi_wr: cover property (wr_status ##1 bvalid);

endmodule

`default_nettype wire

// ===== op_feed.sv
// decode and operand-fetch stand-in: presents one operation per call
// assumes the caller waits for the answer before the next call
`timescale 1ns/1ps
`default_nettype none

module op_feed
    import ext_alu_pkg::*;
(
    input wire logic aclk,
    output logic op_valid,
    output var op_t op_kind,
    output var op_size_t op_size,
    output logic [2:0] op_count,
    output logic op_dst_reg,
    output logic op_dst_imm,
    output logic op_ext_word,
    output logic [19:0] op_src,
    output logic [19:0] op_dst
);
    initial
    begin
        op_valid = 1'b0;
        op_kind = subtract_ext;
        op_size = size_word;
        {op_count, op_dst_reg, op_dst_imm, op_ext_word} = 6'h0;
        {op_src, op_dst} = 40'h0;
    end

    // md is {extension word, immediate, register}
    task automatic issue(input op_t k, input op_size_t s, input logic [2:0] n,
                         input logic [2:0] md, input logic [19:0] src, input logic [19:0] dst);
        @(posedge aclk);
        op_valid <= 1'b1;
        op_kind <= k;
        op_size <= s;
        op_count <= n;
        {op_ext_word, op_dst_imm, op_dst_reg} <= md;
        op_src <= src;
        op_dst <= dst;
        @(posedge aclk);
        op_valid <= 1'b0;
        // stale operands are not left looking valid
        op_src <= ~src;
        op_dst <= ~dst;
    endtask
endmodule

`default_nettype wire

// ===== ext_shift_subtract_alu_tb.sv
// self-checking bench for the shift/subtract slice
// assumes the slice and op_feed compile beside it
`timescale 1ns/1ps
`default_nettype none
`include "ext_alu_params.svh"

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module ext_shift_subtract_alu_tb
    import ext_alu_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, op_valid;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, rsp;
    op_t op_kind;
    op_size_t op_size;
    logic [2:0] op_count;
    logic op_dst_reg, op_dst_imm, op_ext_word;
    logic [19:0] op_src, op_dst, res_data_r, exp_r;
    logic res_valid_r, res_fault_r, flag_n_r, flag_z_r, flag_c_r, flag_v_r;
    logic global_irq_enable, core_halt_bit, oscillator_halt_bit;
    logic [3:0] exp_f;
    int num_errors = 0;
    int n_compared = 0;

    always #25 aclk = ~aclk;

    ext_shift_subtract_alu u_ext_shift_subtract_alu (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .op_valid, .op_kind, .op_size,
        .op_count, .op_dst_reg, .op_dst_imm, .op_ext_word, .op_src, .op_dst, .res_valid_r,
        .res_fault_r, .res_data_r, .flag_n_r, .flag_z_r, .flag_c_r, .flag_v_r,
        .global_irq_enable, .core_halt_bit, .oscillator_halt_bit);

    op_feed u_op_feed (.aclk, .op_valid, .op_kind, .op_size, .op_count, .op_dst_reg,
        .op_dst_imm, .op_ext_word, .op_src, .op_dst);

    // ************************************************************
    // reference arithmetic: {V, N, Z, C, result}
    // ************************************************************
    function automatic logic [23:0] model(op_t k, op_size_t s, logic [2:0] n,
                                          logic [19:0] src, logic [19:0] dst, logic cin);
        logic [20:0] sum;
        logic [19:0] m, d, b, r;
        logic c, v, top;
        int w;
        w = (s == size_byte) ? 8 : (s == size_word) ? 16 : 20;
        m = (s == size_byte) ? `MASK_BYTE : (s == size_word) ? `MASK_WORD : `MASK_AWORD;
        d = dst & m;
        r = d;
        c = cin;
        v = 1'b0;
        if (k == subtract_ext || k == subtract_borrow_ext)
        begin
            b = (k == subtract_ext) ? (~src & m) : m;
            sum = {1'b0, d} + {1'b0, b} + ((k == subtract_ext) ? 21'h1 : {20'h0, cin});
            c = sum[w];
            r = sum[19:0] & m;
            v = (d[w-1] == b[w-1]) && (r[w-1] != d[w-1]);
        end
        else
        begin
            repeat ((k inside {shift_right_arith_multi, rotate_carry_multi,
                               shift_unsigned_multi}) ? int'(n) : 1)
            begin
                top = (k inside {shift_right_arith_single, shift_right_arith_multi}) ? r[w-1]
                    : (k inside {rotate_carry_single, rotate_carry_multi}) ? c : 1'b0;
                c = r[0];
                r = (r >> 1) | ({19'h0, top} << (w - 1));
            end
        end
        return {v, r[w-1], (r == 20'h0), c, r};
    endfunction

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        `CHK({rresp, rdata}, {er, ed})
    endtask

    task automatic do_op(input op_t k, input op_size_t s, input logic [2:0] n,
                         input logic [2:0] md, input logic [19:0] src, input logic [19:0] dst);
        logic [23:0] e;
        e = model(k, s, n, src, dst, exp_f[0]);
        u_op_feed.issue(k, s, n, md, src, dst);
        #1;
        `CHK({res_valid_r, res_fault_r}, 2'b10)
        `CHK({flag_v_r, flag_n_r, flag_z_r, flag_c_r, res_data_r}, e)
        {exp_f, exp_r} = e;
    endtask

    task automatic do_bad(input op_t k, input op_size_t s, input logic [2:0] n,
                          input logic [2:0] md);
        u_op_feed.issue(k, s, n, md, 20'h12345, 20'h0ABCD);
        #1;
        `CHK({res_valid_r, res_fault_r}, 2'b01)
        `CHK({flag_v_r, flag_n_r, flag_z_r, flag_c_r, res_data_r}, {exp_f, exp_r})
    endtask

    task automatic summarize();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 40'h0;
        wstrb = 4'hF;
        exp_f = 4'h0;
        exp_r = 20'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(`OFS_STATUS, 32'h0, `RESP_OKAY);
        rd_chk(`OFS_RESULT, 32'h0, `RESP_OKAY);
        rd_chk(4'hC, 32'h0, `RESP_SLVERR);
        axi_wr(4'h8, 32'hFF, rsp);
        `CHK(rsp, `RESP_SLVERR)
        axi_wr(`OFS_STATUS, 32'h71, rsp);
        exp_f = 4'h1;
        do_op(subtract_ext, size_word, 3'h0, 3'b001, 20'h1, 20'h1);
        do_op(subtract_ext, size_byte, 3'h0, 3'b000, 20'h80, 20'h01);
        do_op(subtract_ext, size_aword, 3'h0, 3'b001, 20'h1, 20'h80000);
        do_op(subtract_borrow_ext, size_word, 3'h0, 3'b001, 20'h0, 20'h0);
        do_op(subtract_borrow_ext, size_aword, 3'h0, 3'b000, 20'h0, 20'h5);
        do_op(subtract_borrow_ext, size_byte, 3'h0, 3'b001, 20'h0, 20'h80);
        do_op(shift_right_arith_single, size_byte, 3'h0, 3'b001, 20'h0, 20'hABC81);
        do_op(shift_right_arith_single, size_aword, 3'h0, 3'b000, 20'h0, 20'h80002);
        do_op(shift_right_arith_single, size_word, 3'h0, 3'b001, 20'h0, 20'hF4000);
        do_op(rotate_carry_single, size_word, 3'h0, 3'b001, 20'h0, 20'hF0001);
        do_op(rotate_carry_single, size_byte, 3'h0, 3'b000, 20'h0, 20'h00003);
        do_op(rotate_carry_single, size_aword, 3'h0, 3'b000, 20'h0, 20'h00001);
        do_op(shift_unsigned_single, size_word, 3'h0, 3'b001, 20'h0, 20'h38001);
        for (int i = 1; i <= 4; i++)
        begin
            do_op(shift_right_arith_multi, size_aword, 3'(i), 3'b001, 20'h0, 20'h8000F);
            do_op(rotate_carry_multi, size_word, 3'(i), 3'b001, 20'h0, 20'hA5A5A);
            do_op(rotate_carry_multi, size_aword, 3'(i), 3'b001, 20'h0, 20'h0000F);
            do_op(shift_unsigned_multi, size_word, 3'(i), 3'b001, 20'h0, 20'hFFFF7);
            do_op(shift_unsigned_multi, size_aword, 3'(i), 3'b001, 20'h0, 20'h80000);
        end
        do_bad(shift_unsigned_multi, size_word, 3'h2, 3'b101);
        do_bad(shift_right_arith_multi, size_word, 3'h2, 3'b000);
        do_bad(rotate_carry_multi, size_word, 3'h0, 3'b001);
        do_bad(rotate_carry_multi, size_aword, 3'h5, 3'b001);
        do_bad(shift_unsigned_multi, size_byte, 3'h1, 3'b001);
        do_bad(shift_unsigned_single, size_word, 3'h0, 3'b000);
        do_bad(shift_right_arith_single, size_word, 3'h0, 3'b010);
        do_bad(rotate_carry_single, op_size_t'(2'h3), 3'h0, 3'b001);
        `CHK({oscillator_halt_bit, core_halt_bit, global_irq_enable}, 3'b111)
        rd_chk(`OFS_STATUS, {25'h0, 3'b111, exp_f}, `RESP_OKAY);
        // status lives in byte 0: a write without that lane leaves it alone
        wstrb <= 4'hE;
        axi_wr(`OFS_STATUS, 32'h0, rsp);
        `CHK(rsp, `RESP_OKAY)
        rd_chk(`OFS_STATUS, {25'h0, 3'b111, exp_f}, `RESP_OKAY);
        wstrb <= 4'hF;
        axi_wr(`OFS_RESULT, 32'h12345, rsp);
        `CHK(rsp, `RESP_OKAY)
        rd_chk(`OFS_RESULT, {12'h0, exp_r}, `RESP_OKAY);
        axi_wr(`OFS_STATUS, 32'hFFFFFF80, rsp);
        rd_chk(`OFS_STATUS, 32'h0, `RESP_OKAY);
        summarize();
    end

    initial
    begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        summarize();
    end
endmodule

`default_nettype wire
